// >>> rtl/sar_adc_mux_control_pkg.sv
// Purpose: Shared constants and types for the approximation converter control block
// Assumes: APB registers, one aligned 32-bit word each
// Notes: Register offsets are byte addresses
package sar_adc_mux_control_pkg;

	// Register offsets
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_RESULT = 8'h04;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;

	// Status register field positions
	localparam int STS_DONE_BIT = 0;
	localparam int STS_BUSY_BIT = 1;
	localparam int STS_CHAN_LSB = 4;
	localparam int STS_RESULT_LSB = 8;

	// Interrupt event bit positions
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_ABORT_BIT = 1;
	localparam int IRQ_BITS = 2;

	// Reset values
	localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
	localparam logic [7:0] RESULT_RESET = 8'h00;
	localparam logic [3:0] CHAN_RESET = 4'h0;

	// Timing counts
	localparam int RESULT_BITS = 8;
	localparam int TRIAL_CLKS = 8;
	localparam int SYS_CLK_HZ = 20000000;
	localparam int CONV_CLK_HZ = 625000;
	localparam int CONV_DIV = SYS_CLK_HZ / CONV_CLK_HZ - 1;

	typedef enum logic [4:0]
	{
		ST_IDLE = 5'h01,
		ST_ARMED = 5'h02,
		ST_CONV = 5'h04,
		ST_LOAD = 5'h08,
		ST_DONE = 5'h10
	} conv_state_t;

endpackage : sar_adc_mux_control_pkg

// >>> rtl/pin_sync.sv
// Purpose: Two-stage synchroniser for a group of pin inputs
// Assumes: Each bit is a slow level; no bit relation is kept across the group
// Notes: The first stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] stable_q;

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_q <= '0;
			stable_q <= '0;
		end
		else
		begin
			meta_q <= pin_in;
			stable_q <= meta_q;
		end
	end

	assign pin_sync_out = stable_q;

endmodule : pin_sync

// >>> rtl/sar_adc_mux_control.sv
// Purpose: Digital control of an 8-bit approximation converter with 16-input selector
// Assumes: clk_sys 20 MHz; conversion clock is a divided tick of clk_sys
// Notes: Analog ladder and comparator live outside; comp_high reports the trial
// Summary of operation
// - The channel select bits are caught on the rising edge of the address strobe and kept.
// - With mux gate high the four select bits pick one of sixteen inputs in binary order.
// - With mux gate low every channel switch is off whatever the select bits hold.
// - The bit trial register is cleared on the rising edge of the convert trigger.
// - A conversion starts only on the falling edge of the convert trigger.
// - A new trigger pulse during a conversion abandons it and restarts from the new pulse.
// - The done output may be looped back to the trigger for continuous conversion.
// - Done goes low within 0 to 8 conversion clocks after the trigger rises.
// - Each conversion runs 8 bit trials from the top bit down to form the result.
// - The data latch is loaded one conversion clock before done rises.
// - The result is straight binary with a high output meaning a one.
// - Data outputs drive while output enable is high and float while it is low.
`timescale 1ns/1ps
module sar_adc_mux_control #(
	parameter int CONV_DIV = sar_adc_mux_control_pkg::CONV_DIV
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic convert_trigger,
	input wire logic addr_strobe,
	input wire logic [3:0] chan_sel,
	input wire logic mux_gate,
	input wire logic out_enable,
	input wire logic comp_high,
	output logic conversion_done,
	output logic [15:0] channel_on,
	output logic [7:0] ladder_tap,
	output logic [7:0] data_out,
	output logic data_oe_n
);

	// Elaboration check: the tick divider is eight bits wide
	if (CONV_DIV < 1 || CONV_DIV > 200)
	begin : g_bad_div
		$error("CONV_DIV out of range");
	end

	localparam int SYNC_W = 9;

	logic [SYNC_W-1:0] pins_s;
	logic trig_s;
	logic strobe_s;
	logic [3:0] sel_s;
	logic gate_s;
	logic oe_s;
	logic comp_s;
	logic trig_prev_q;
	logic strobe_prev_q;
	logic trig_rise;
	logic trig_fall;
	logic strobe_rise;
	logic [7:0] div_q;
	logic tick;
	logic [2:0] trial_cnt_q;
	logic [2:0] bit_idx_q;
	logic trial_end;
	sar_adc_mux_control_pkg::conv_state_t state_q;
	logic [7:0] bit_trial_register_q;
	logic [7:0] data_q;
	logic data_oe_n_q;
	logic done_q;
	logic [3:0] addr_q;
	logic [15:0] channel_on_q;
	logic load_stb;
	logic done_evt;
	logic abort_evt;
	logic [1:0] irq_status_q;
	logic [1:0] irq_mask_q;
	logic irq_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] rd_d;
	logic hit_d;
	logic apb_setup;
	logic apb_access;
	logic irq_clr_q;
	logic [1:0] irq_clr_bits_q;

	pin_sync #(
		.WIDTH(SYNC_W)
	) u_pin_sync (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.pin_in({comp_high, out_enable, mux_gate, chan_sel, addr_strobe, convert_trigger}),
		.pin_sync_out(pins_s)
	);

	assign trig_s = pins_s[0];
	assign strobe_s = pins_s[1];
	assign sel_s = pins_s[5:2];
	assign gate_s = pins_s[6];
	assign oe_s = pins_s[7];
	assign comp_s = pins_s[8];

	// Edge detection on the synchronised levels
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			trig_prev_q <= 1'b0;
			strobe_prev_q <= 1'b0;
		end
		else
		begin
			trig_prev_q <= trig_s;
			strobe_prev_q <= strobe_s;
		end
	end

	assign trig_rise = trig_s && !trig_prev_q;
	assign trig_fall = !trig_s && trig_prev_q;
	assign strobe_rise = strobe_s && !strobe_prev_q;

	// Free-running conversion clock tick
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			div_q <= 8'h00;
		else if (div_q == 8'(CONV_DIV))
			div_q <= 8'h00;
		else
			div_q <= div_q + 8'h01;
	end

	assign tick = (div_q == 8'(CONV_DIV));
	assign trial_end = tick && (trial_cnt_q == 3'(sar_adc_mux_control_pkg::TRIAL_CLKS - 1));
	assign load_stb = (state_q == sar_adc_mux_control_pkg::ST_CONV) && trial_end
		&& (bit_idx_q == 3'h0);
	assign done_evt = (state_q == sar_adc_mux_control_pkg::ST_LOAD) && tick && !trig_rise;
	assign abort_evt = trig_rise && ((state_q == sar_adc_mux_control_pkg::ST_CONV)
		|| (state_q == sar_adc_mux_control_pkg::ST_LOAD));

	// Conversion sequencer
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= sar_adc_mux_control_pkg::ST_IDLE;
			bit_trial_register_q <= 8'h00;
			trial_cnt_q <= 3'h0;
			bit_idx_q <= 3'h7;
		end
		else if (trig_rise)
		begin
			state_q <= sar_adc_mux_control_pkg::ST_ARMED;
			bit_trial_register_q <= 8'h00;
			trial_cnt_q <= 3'h0;
			bit_idx_q <= 3'h7;
		end
		else
		begin
			case (state_q)
				sar_adc_mux_control_pkg::ST_ARMED:
				begin
					if (trig_fall)
					begin
						state_q <= sar_adc_mux_control_pkg::ST_CONV;
						bit_trial_register_q <= 8'h80;
						trial_cnt_q <= 3'h0;
						bit_idx_q <= 3'h7;
					end
				end
				sar_adc_mux_control_pkg::ST_CONV:
				begin
					if (tick)
						trial_cnt_q <= trial_cnt_q + 3'h1;
					if (trial_end)
					begin
						// Keep the trial bit when the input is at or above the tap
						bit_trial_register_q[bit_idx_q] <= comp_s;
						if (bit_idx_q == 3'h0)
							state_q <= sar_adc_mux_control_pkg::ST_LOAD;
						else
						begin
							bit_trial_register_q[bit_idx_q - 3'h1] <= 1'b1;
							bit_idx_q <= bit_idx_q - 3'h1;
						end
					end
				end
				sar_adc_mux_control_pkg::ST_LOAD:
				begin
					if (tick)
						state_q <= sar_adc_mux_control_pkg::ST_DONE;
				end
				default:
				begin
					state_q <= state_q;
				end
			endcase
		end
	end

	// Result latch; last bit decision is folded in while loading
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			data_q <= sar_adc_mux_control_pkg::RESULT_RESET;
		else if (load_stb && !trig_rise)
			data_q <= {bit_trial_register_q[7:1], comp_s};
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			done_q <= 1'b0;
		else if (trig_rise)
			done_q <= 1'b0;
		else if (done_evt)
			done_q <= 1'b1;
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			data_oe_n_q <= 1'b1;
		else
			data_oe_n_q <= !oe_s;
	end

	// Channel address latch and switch decode
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			addr_q <= sar_adc_mux_control_pkg::CHAN_RESET;
		else if (strobe_rise)
			addr_q <= sel_s;
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			channel_on_q <= 16'h0000;
		else if (gate_s)
			channel_on_q <= 16'h0001 << addr_q;
		else
			channel_on_q <= 16'h0000;
	end

	// APB slave: answer registered, no wait states per transfer
	assign apb_setup = psel && !penable;
	assign apb_access = psel && penable && pready_q;

	always_comb
	begin
		rd_d = 32'h0000_0000;
		hit_d = 1'b1;
		if (paddr == sar_adc_mux_control_pkg::OFS_STATUS)
		begin
			rd_d[sar_adc_mux_control_pkg::STS_DONE_BIT] = done_q;
			rd_d[sar_adc_mux_control_pkg::STS_BUSY_BIT] = !(state_q == sar_adc_mux_control_pkg::ST_IDLE
				|| state_q == sar_adc_mux_control_pkg::ST_DONE);
			rd_d[sar_adc_mux_control_pkg::STS_CHAN_LSB +: 4] = addr_q;
			rd_d[sar_adc_mux_control_pkg::STS_RESULT_LSB +: 8] = data_q;
		end
		else if (paddr == sar_adc_mux_control_pkg::OFS_RESULT)
			rd_d[7:0] = data_q;
		else if (paddr == sar_adc_mux_control_pkg::OFS_IRQ_STATUS)
			rd_d[1:0] = irq_status_q;
		else if (paddr == sar_adc_mux_control_pkg::OFS_IRQ_MASK)
			rd_d[1:0] = irq_mask_q;
		else
			hit_d = 1'b0;
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
			irq_clr_q <= 1'b0;
			irq_clr_bits_q <= 2'h0;
		end
		else
		begin
			pready_q <= apb_setup;
			if (apb_setup)
			begin
				prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
				pslverr_q <= !hit_d;
				irq_clr_q <= !pwrite && (paddr == sar_adc_mux_control_pkg::OFS_IRQ_STATUS);
				irq_clr_bits_q <= irq_status_q;
			end
			else if (apb_access)
			begin
				pslverr_q <= 1'b0;
				irq_clr_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			irq_mask_q <= sar_adc_mux_control_pkg::IRQ_MASK_RESET;
		else if (apb_access && pwrite && paddr == sar_adc_mux_control_pkg::OFS_IRQ_MASK)
			irq_mask_q <= pwdata[1:0];
	end

	// Read clears only the bits that were returned; a new event wins
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			irq_status_q <= 2'h0;
		else
			irq_status_q <= (irq_status_q & ~((apb_access && irq_clr_q) ? irq_clr_bits_q : 2'h0))
				| {abort_evt, done_evt};
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			irq_q <= 1'b0;
		else
			irq_q <= |(irq_status_q & irq_mask_q);
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;
	assign conversion_done = done_q;
	assign channel_on = channel_on_q;
	assign ladder_tap = bit_trial_register_q;
	assign data_out = data_q;
	assign data_oe_n = data_oe_n_q;

	// Helper: cycles since the result latch was loaded
	logic [7:0] since_load_q;
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			since_load_q <= 8'hFF;
		else if (load_stb && !trig_rise)
			since_load_q <= 8'h00;
		else if (since_load_q != 8'hFF)
			since_load_q <= since_load_q + 8'h01;
	end

	// Helper: cycles since the last bit decision, counted only while converting
	localparam logic [11:0] TRIAL_LEN_M1 = 12'(sar_adc_mux_control_pkg::TRIAL_CLKS
		* (CONV_DIV + 1) - 1);
	logic [11:0] trial_clks_q;
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			trial_clks_q <= 12'h000;
		else if (state_q != sar_adc_mux_control_pkg::ST_CONV || trial_end)
			trial_clks_q <= 12'h000;
		else
			trial_clks_q <= trial_clks_q + 12'h001;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	a_addr_hold: assert property (!strobe_rise |=> addr_q == $past(addr_q))
		else $error("channel address changed without strobe");
	a_mux_select: assert property (gate_s && !strobe_rise |=> channel_on_q == (16'h0001 << addr_q))
		else $error("wrong channel switch on");
	a_mux_off: assert property (!gate_s |=> channel_on_q == 16'h0000)
		else $error("channel on while gate low");
	a_trial_clear: assert property (trig_rise |=> bit_trial_register_q == 8'h00)
		else $error("trial register not cleared");
	a_start_fall: assert property ($rose(state_q == sar_adc_mux_control_pkg::ST_CONV) |-> $past(trig_fall))
		else $error("conversion began without falling trigger");
	a_abort_restart: assert property (trig_rise && state_q == sar_adc_mux_control_pkg::ST_CONV
		|=> state_q == sar_adc_mux_control_pkg::ST_ARMED && !done_q)
		else $error("running conversion not abandoned");
	a_done_low: assert property (trig_rise |=> !done_q)
		else $error("done not lowered after trigger");
	a_last_trial: assert property (trial_end && bit_idx_q == 3'h0 && state_q == sar_adc_mux_control_pkg::ST_CONV
		&& !trig_rise |=> state_q == sar_adc_mux_control_pkg::ST_LOAD)
		else $error("conversion did not end after bit 0");
	a_latch_lead: assert property ($rose(done_q) |-> since_load_q == 8'(CONV_DIV + 1))
		else $error("latch not loaded one conversion clock before done");
	a_load_value: assert property (load_stb && !trig_rise |=> data_q == {$past(bit_trial_register_q[7:1]), $past(comp_s)})
		else $error("latched result differs from trials");
	a_oe_follow: assert property (oe_s |=> !data_oe_n_q ##1 (data_oe_n_q == !$past(oe_s)))
		else $error("output enable not followed");
	a_done_hold: assert property (done_q && !trig_rise |=> done_q)
		else $error("done dropped without trigger");
	a_trial_len: assert property (trial_end && bit_idx_q != 3'h7
		&& state_q == sar_adc_mux_control_pkg::ST_CONV |-> trial_clks_q == TRIAL_LEN_M1)
		else $error("bit trial length wrong");
	a_latch_hold: assert property (!(load_stb && !trig_rise) |=> data_q == $past(data_q))
		else $error("result latch changed outside load");

	c_full_conv: cover property ($rose(done_q));
	c_abort: cover property (abort_evt);
	c_irq: cover property ($rose(irq_q));
	c_gate_off: cover property (!gate_s && strobe_rise);

endmodule : sar_adc_mux_control

// >>> tb/analog_front.sv
// Purpose: Far-side model of selector inputs and comparator
// Assumes: Input n sits at level n*8'h11; ext_level feeds the comparator with all switches off
// Notes: Combinational, so the comparator answers within the trial
`timescale 1ns/1ps
module analog_front (
	input wire logic [15:0] channel_on,
	input wire logic [7:0] ladder_tap,
	input wire logic [7:0] ext_level,
	output logic comp_high
);
	logic [7:0] level;
	always_comb
	begin
		level = ext_level;
		for (int i = 0; i < 16; i++)
			if (channel_on[i])
				level = 8'(i * 17);
	end
	assign comp_high = level >= ladder_tap;
endmodule : analog_front

// >>> tb/test_sar_adc_mux_control.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: CONV_DIV 3, so one conversion tick is 4 clocks
// Notes: Inputs change by NBA just after rising edges
`timescale 1ns/1ps
module test_sar_adc_mux_control;
	localparam int TICK = 4;
	logic clk_sys = 1'b0;
	logic arst_n, psel, penable, pwrite, pready, pslverr, irq, trig, loop_en;
	logic addr_strobe, mux_gate, out_enable, comp_high, conversion_done, data_oe_n, last_done;
	logic [7:0] paddr, ladder_tap, data_out, ext_level, last_d;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] chan_sel;
	logic [15:0] channel_on;
	logic e;
	int n_errors = 0;
	int check_count = 0;
	int cnt = 0;
	int load_at = 0;
	int rises = 0;
	wire logic convert_trigger = trig | (loop_en & conversion_done);
	always #25 clk_sys = ~clk_sys;
	sar_adc_mux_control #(.CONV_DIV(3)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.convert_trigger(convert_trigger), .addr_strobe(addr_strobe), .chan_sel(chan_sel),
		.mux_gate(mux_gate), .out_enable(out_enable), .comp_high(comp_high),
		.conversion_done(conversion_done), .channel_on(channel_on), .ladder_tap(ladder_tap),
		.data_out(data_out), .data_oe_n(data_oe_n));
	analog_front front_u (.channel_on(channel_on), .ladder_tap(ladder_tap),
		.ext_level(ext_level), .comp_high(comp_high));
	// Remembers when the data latch last changed and counts done rises
	always @(posedge clk_sys)
	begin
		cnt <= cnt + 1;
		last_d <= data_out;
		last_done <= conversion_done;
		if (data_out !== last_d)
			load_at <= cnt;
		if (conversion_done === 1'b1 && last_done === 1'b0)
			rises <= rises + 1;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc
	task automatic chk(input string what, input logic [31:0] exp_v, input logic [31:0] got);
		check_count++;
		if (got !== exp_v)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp_v, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// Answer is taken at the rising edge where pready is seen high; watchdog bounds it
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] exp_v, input logic err_v);
		apb(1'b0, a, 32'h0);
		chk("prdata", exp_v, r);
		chk("pslverr", {31'h0, err_v}, {31'h0, e});
	endtask : rd
	task automatic sel(input logic [3:0] ch);
		chan_sel <= ch;
		cyc(4);
		addr_strobe <= 1'b1;
		cyc(4);
		addr_strobe <= 1'b0;
		cyc(4);
	endtask : sel
	task automatic conv(input logic [7:0] exp_v);
		int n;
		trig <= 1'b1;
		cyc(6);
		chk("done low", 0, conversion_done);
		chk("tap cleared", 0, ladder_tap);
		trig <= 1'b0;
		n = 0;
		while (ladder_tap !== 8'h80 && n < 12)
		begin
			cyc(1);
			n++;
		end
		chk("first trial", 8'h80, ladder_tap);
		n = 0;
		while (conversion_done !== 1'b1 && n < 400)
		begin
			cyc(1);
			n++;
		end
		chk("result", exp_v, data_out);
		chk("load lead", TICK, cnt - load_at);
		chk("length", 1, n >= 64 * TICK && n <= 66 * TICK);
		cyc(2);
	endtask : conv
	task automatic t_sel;
		for (int ch = 0; ch < 16; ch++)
		begin
			sel(4'(ch));
			chk("switch", 16'h1 << ch, channel_on);
		end
		chan_sel <= 4'h2;
		cyc(6);
		chk("switch held", 16'h8000, channel_on);
		$display("t_sel done");
	endtask : t_sel
	task automatic t_conv;
		sel(4'hC);
		conv(8'hCC);
		rd(sarpkg_ofs(0), {16'h0, 8'hCC, 8'hC1}, 1'b0);
		rd(8'h04, 32'h0000_00CC, 1'b0);
		chk("done stays", 1, conversion_done);
		sel(4'hF);
		conv(8'hFF);
		sel(4'h0);
		conv(8'h00);
		$display("t_conv done");
	endtask : t_conv
	function automatic logic [7:0] sarpkg_ofs(input int i);
		return (i == 0) ? sar_adc_mux_control_pkg::OFS_STATUS : 8'h00;
	endfunction : sarpkg_ofs
	task automatic t_gate;
		mux_gate <= 1'b0;
		ext_level <= 8'hA5;
		cyc(6);
		chk("all off", 0, channel_on);
		sel(4'h5);
		chk("off after strobe", 0, channel_on);
		conv(8'hA5);
		mux_gate <= 1'b1;
		$display("t_gate done");
	endtask : t_gate
	task automatic t_abort;
		apb(1'b0, sar_adc_mux_control_pkg::OFS_IRQ_STATUS, 32'h0);
		sel(4'h3);
		trig <= 1'b1;
		cyc(4);
		trig <= 1'b0;
		cyc(60);
		chk("latch kept", 8'hA5, data_out);
		conv(8'h33);
		rd(sar_adc_mux_control_pkg::OFS_IRQ_STATUS, 32'h3, 1'b0);
		rd(sar_adc_mux_control_pkg::OFS_IRQ_STATUS, 32'h0, 1'b0);
		$display("t_abort done");
	endtask : t_abort
	task automatic t_irq;
		apb(1'b1, sar_adc_mux_control_pkg::OFS_IRQ_MASK, 32'h1);
		rd(sar_adc_mux_control_pkg::OFS_IRQ_MASK, 32'h1, 1'b0);
		sel(4'h6);
		conv(8'h66);
		cyc(3);
		chk("irq up", 1, irq);
		rd(sar_adc_mux_control_pkg::OFS_IRQ_STATUS, 32'h1, 1'b0);
		cyc(2);
		chk("irq down", 0, irq);
		apb(1'b1, sar_adc_mux_control_pkg::OFS_IRQ_MASK, 32'h0);
		sel(4'h9);
		conv(8'h99);
		cyc(3);
		chk("irq masked", 0, irq);
		rd(sar_adc_mux_control_pkg::OFS_IRQ_STATUS, 32'h1, 1'b0);
		$display("t_irq done");
	endtask : t_irq
	task automatic t_oe;
		out_enable <= 1'b0;
		cyc(6);
		chk("float", 1, data_oe_n);
		out_enable <= 1'b1;
		cyc(6);
		chk("drive", 0, data_oe_n);
		$display("t_oe done");
	endtask : t_oe
	task automatic t_loop;
		int start;
		sel(4'h7);
		loop_en <= 1'b1;
		start = rises;
		trig <= 1'b1;
		cyc(4);
		trig <= 1'b0;
		cyc(900);
		chk("loop runs", 1, rises - start >= 3);
		chk("loop result", 8'h77, data_out);
		loop_en <= 1'b0;
		cyc(300);
		$display("t_loop done");
	endtask : t_loop
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		$display("ERROR watchdog expected finish seen hang");
		test_done();
	end
	initial
	begin
		arst_n = 1'b0;
		{psel, penable, pwrite, trig, loop_en, addr_strobe} = 6'h00;
		{mux_gate, out_enable} = 2'h3;
		paddr = 8'h00;
		pwdata = 32'h0;
		chan_sel = 4'h0;
		ext_level = 8'h00;
		cyc(3);
		chk("reset oe", 1, data_oe_n);
		chk("reset data", 0, data_out);
		chk("reset irq", 0, irq);
		arst_n <= 1'b1;
		cyc(3);
		rd(sar_adc_mux_control_pkg::OFS_IRQ_MASK, 32'h0, 1'b0);
		rd(8'h10, 32'h0, 1'b1);
		$display("t_reset done");
		t_sel();
		t_conv();
		t_gate();
		t_abort();
		t_irq();
		t_oe();
		t_loop();
		test_done();
	end
endmodule : test_sar_adc_mux_control
